/* File: hw/port_ingress_pkg.sv */
package port_ingress_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ACL_BE_LSB_OFS = 16'h0611;
  localparam logic [15:0] ACL_CTRL_OFS = 16'h0612;
  localparam logic [15:0] MIRROR_OFS = 16'h0800;
  localparam logic [15:0] PRIO_CTRL_OFS = 16'h0801;
  localparam logic [11:0] PORT_OFS_MASK = 12'hFFF;

  // acl control fields
  localparam int ACL_WR_DONE_BIT = 6;
  localparam int ACL_RD_DONE_BIT = 5;
  localparam int ACL_DIR_BIT = 4;
  localparam int ACL_IDX_MSB = 3;
  localparam logic [7:0] ACL_CTRL_RW_MASK = 8'h1F;

  // mirroring fields
  localparam int MIR_RX_BIT = 6;
  localparam int MIR_TX_BIT = 5;
  localparam int MIR_SNIFFER_BIT = 1;
  localparam logic [7:0] MIRROR_RW_MASK = 8'h62;

  // priority control fields
  localparam int PRI_HIGHEST_BIT = 7;
  localparam int PRI_OR_BIT = 6;
  localparam int PRI_MAC_BIT = 4;
  localparam int PRI_VLAN_BIT = 3;
  localparam int PRI_DOT1P_BIT = 2;
  localparam int PRI_DIFFSERV_BIT = 1;
  localparam int PRI_ACL_BIT = 0;
  localparam logic [7:0] PRIO_RW_MASK = 8'hDF;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] ACL_LAT_DEFAULT = 4'h4;

  // indirect table engine states
  typedef enum logic [1:0]
  {
    TBL_IDLE = 2'b00,
    TBL_BUSY = 2'b01
  } tbl_state_e;

endpackage : port_ingress_pkg

/* File: hw/acl_table_engine.sv */
module acl_table_engine
  import port_ingress_pkg::*;
#(
  parameter int LAT = 4
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // request
  input wire logic start,
  input wire logic dir_write,
  // status
  output logic wr_done,
  output logic rd_done,
  output logic busy
);

  tbl_state_e state_q;
  logic [7:0] cnt_q;
  logic op_write_q;

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= TBL_IDLE;
      cnt_q <= 8'h00;
      op_write_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        TBL_IDLE:
        begin
          if (start)
          begin
            state_q <= TBL_BUSY;
            cnt_q <= 8'(LAT);
            op_write_q <= dir_write;
          end
        end
        TBL_BUSY:
        begin
          if (cnt_q <= 8'h01)
            state_q <= TBL_IDLE;
          else
            cnt_q <= cnt_q - 8'h01;
        end
      endcase
    end
  end

  // completion flags high at reset and when idle
  assign busy = (state_q == TBL_BUSY);
  assign wr_done = !(busy && op_write_q);
  assign rd_done = !(busy && !op_write_q);

endmodule : acl_table_engine

/* File: hw/prio_select.sv */
module prio_select
  import port_ingress_pkg::*;
(
  // control
  input wire logic [7:0] prio_ctrl,
  input wire logic [2:0] default_prio,
  // classifier results
  input wire logic [2:0] mac_prio,
  input wire logic mac_hit,
  input wire logic [2:0] vlan_prio,
  input wire logic vlan_hit,
  input wire logic [2:0] dot1p_prio,
  input wire logic dot1p_hit,
  input wire logic [2:0] dscp_prio,
  input wire logic dscp_hit,
  input wire logic [2:0] acl_prio,
  input wire logic acl_hit,
  // result
  output logic [2:0] prio
);

  logic use_mac;
  logic use_vlan;
  logic use_dot1p;
  logic use_dscp;
  logic use_acl;

  // classifier gating
  assign use_mac = prio_ctrl[PRI_MAC_BIT] && mac_hit;
  assign use_vlan = prio_ctrl[PRI_VLAN_BIT] && vlan_hit;
  assign use_dot1p = prio_ctrl[PRI_DOT1P_BIT] && dot1p_hit;
  assign use_dscp = prio_ctrl[PRI_DIFFSERV_BIT] && dscp_hit;
  assign use_acl = prio_ctrl[PRI_ACL_BIT] && acl_hit;

  // combine available results
  always_comb
  begin
    logic [2:0] hi;
    logic [2:0] orv;
    logic any;
    hi = 3'h0;
    orv = 3'h0;
    any = use_mac || use_vlan || use_dot1p || use_dscp || use_acl;
    if (use_mac && mac_prio > hi) hi = mac_prio;
    if (use_vlan && vlan_prio > hi) hi = vlan_prio;
    if (use_dot1p && dot1p_prio > hi) hi = dot1p_prio;
    if (use_dscp && dscp_prio > hi) hi = dscp_prio;
    if (use_acl && acl_prio > hi) hi = acl_prio;
    if (use_mac) orv = orv | mac_prio;
    if (use_vlan) orv = orv | vlan_prio;
    if (use_dot1p) orv = orv | dot1p_prio;
    if (use_dscp) orv = orv | dscp_prio;
    if (use_acl) orv = orv | acl_prio;
    if (!any)
      prio = default_prio;
    else if (prio_ctrl[PRI_HIGHEST_BIT])
      prio = hi;
    else if (prio_ctrl[PRI_OR_BIT])
      prio = orv;
    else if (use_acl)
      prio = acl_prio;
    else if (use_mac)
      prio = mac_prio;
    else if (use_dscp)
      prio = dscp_prio;
    else if (use_dot1p)
      prio = dot1p_prio;
    else
      prio = vlan_prio;
  end

endmodule : prio_select

/* File: hw/port_ingress_ctrl_regs.sv */
// Function
// - write-complete status bit 6 reads 0 during table write, 1 otherwise and after reset.
// - read-complete status bit 5 reads 0 during table read, 1 otherwise and after reset.
// - writing low byte-enable register starts the operation with enabled bytes only.
// - receive sniff bit 6 marks received packets monitored for sniffer port.
// - transmit sniff bit 5 marks transmitted packets monitored for sniffer port.
// - sniffer bit 1 makes this port transmit monitored packets.
// - bit 7 selects highest of available priority results.
// - bit 6 ORs all available priority results when bit 7 is clear.
// - bit 4 enables MAC address priority classification.
// - bit 3 enables VLAN priority classification.
// - bit 2 enables 802.1p priority classification.
// - bit 1 enables Diffserv priority classification.
// - bit 0 enables access-control-list priority classification.
// - unclassified packets take the port default priority 0 to 7.
module port_ingress_ctrl_regs
  import port_ingress_pkg::*;
#(
  parameter int ACL_LAT = 4
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register access (byte wide, port-local offset)
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // byte enables staged by neighbouring registers
  input wire logic [7:0] acl_be_msb,
  // table access request towards table memory
  output logic tbl_start,
  output logic tbl_write,
  output logic [3:0] tbl_index,
  output logic [15:0] tbl_byte_en,
  // ingress packet events
  input wire logic rx_pkt,
  input wire logic tx_pkt,
  output logic rx_monitored,
  output logic tx_monitored,
  output logic sniffer_port,
  // port default priority
  input wire logic [2:0] default_prio,
  // mac classifier
  input wire logic [2:0] mac_prio,
  input wire logic mac_hit,
  // vlan classifier
  input wire logic [2:0] vlan_prio,
  input wire logic vlan_hit,
  // 802.1p classifier
  input wire logic [2:0] dot1p_prio,
  input wire logic dot1p_hit,
  // diffserv classifier
  input wire logic [2:0] dscp_prio,
  input wire logic dscp_hit,
  // acl classifier
  input wire logic [2:0] acl_prio,
  input wire logic acl_hit,
  // priority result
  output logic [2:0] ingress_prio
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [15:0] ofs;
  logic hit_acl_ctrl;
  logic hit_mirror;
  logic hit_prio;
  logic hit_be_lsb;
  logic [7:0] acl_ctrl_q;
  logic [7:0] mirror_q;
  logic [7:0] prio_q;
  logic eng_busy;
  logic wr_done;
  logic rd_done;
  logic start;
  logic [2:0] prio_w;
  // write enables
  logic wr_acl_ctrl;
  logic wr_mirror;
  logic wr_prio;
  logic be_lsb_wr;
  // read path
  logic [7:0] acl_status;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  // output registers
  logic tbl_start_q;
  logic tbl_write_q;
  logic [3:0] tbl_index_q;
  logic [15:0] tbl_byte_en_q;
  logic rx_mon_q;
  logic tx_mon_q;
  logic [2:0] ingress_prio_q;

  assign ofs = {4'h0, reg_addr & PORT_OFS_MASK};
  assign hit_acl_ctrl = (ofs == ACL_CTRL_OFS);
  assign hit_mirror = (ofs == MIRROR_OFS);
  assign hit_prio = (ofs == PRIO_CTRL_OFS);
  assign hit_be_lsb = (ofs == ACL_BE_LSB_OFS);

  // per-register write strobes
  assign wr_acl_ctrl = reg_wr && hit_acl_ctrl;
  assign wr_mirror = reg_wr && hit_mirror;
  assign wr_prio = reg_wr && hit_prio;
  assign be_lsb_wr = reg_wr && hit_be_lsb;

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  // acl direction and index
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      acl_ctrl_q <= REG_RESET;
    else if (wr_acl_ctrl)
      acl_ctrl_q <= reg_wdata & ACL_CTRL_RW_MASK;
  end

  // mirroring control
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      mirror_q <= REG_RESET;
    else if (wr_mirror)
      mirror_q <= reg_wdata & MIRROR_RW_MASK;
  end

  // priority control
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      prio_q <= REG_RESET;
    else if (wr_prio)
      prio_q <= reg_wdata & PRIO_RW_MASK;
  end

  // ---------------------------------------------------------------
  // indirect table access
  // ---------------------------------------------------------------
  // start on low byte-enable write, ignored while busy
  assign start = be_lsb_wr && !eng_busy;

  // one-cycle start pulse towards the table
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      tbl_start_q <= 1'b0;
    else
      tbl_start_q <= start;
  end

  // operation parameters captured at start
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tbl_write_q <= 1'b0;
      tbl_index_q <= 4'h0;
      tbl_byte_en_q <= 16'h0000;
    end
    else if (start)
    begin
      tbl_write_q <= acl_ctrl_q[ACL_DIR_BIT];
      tbl_index_q <= acl_ctrl_q[ACL_IDX_MSB:0];
      tbl_byte_en_q <= {acl_be_msb, reg_wdata};
    end
  end

  // engine times the busy window of each operation
  acl_table_engine #(
    .LAT(ACL_LAT)
  ) u_engine (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(start),
    .dir_write(acl_ctrl_q[ACL_DIR_BIT]),
    .wr_done(wr_done),
    .rd_done(rd_done),
    .busy(eng_busy)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // status view, completion flags over stored direction and index
  always_comb
  begin
    acl_status = acl_ctrl_q;
    acl_status[ACL_WR_DONE_BIT] = wr_done;
    acl_status[ACL_RD_DONE_BIT] = rd_done;
  end

  // read data select
  always_comb
  begin
    if (hit_acl_ctrl)
      rdata_d = acl_status;
    else if (hit_mirror)
      rdata_d = mirror_q;
    else if (hit_prio)
      rdata_d = prio_q;
    else
      rdata_d = REG_RESET; // unmapped offsets read zero
  end

  // read answer one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= reg_rd;
  end

  // read data held until the next read
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rdata_q <= REG_RESET;
    else if (reg_rd)
      rdata_q <= rdata_d;
  end

  // ---------------------------------------------------------------
  // mirroring
  // ---------------------------------------------------------------
  // receive mark
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rx_mon_q <= 1'b0;
    else
      rx_mon_q <= rx_pkt && mirror_q[MIR_RX_BIT];
  end

  // transmit mark
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      tx_mon_q <= 1'b0;
    else
      tx_mon_q <= tx_pkt && mirror_q[MIR_TX_BIT];
  end

  // sniffer designation is a plain register level
  assign sniffer_port = mirror_q[MIR_SNIFFER_BIT];

  // ---------------------------------------------------------------
  // priority classification
  // ---------------------------------------------------------------
  // classifier gating and combining
  prio_select u_prio (
    .prio_ctrl(prio_q),
    .default_prio(default_prio),
    .mac_prio(mac_prio),
    .mac_hit(mac_hit),
    .vlan_prio(vlan_prio),
    .vlan_hit(vlan_hit),
    .dot1p_prio(dot1p_prio),
    .dot1p_hit(dot1p_hit),
    .dscp_prio(dscp_prio),
    .dscp_hit(dscp_hit),
    .acl_prio(acl_prio),
    .acl_hit(acl_hit),
    .prio(prio_w)
  );

  // registered priority result
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      ingress_prio_q <= 3'h0;
    else
      ingress_prio_q <= prio_w;
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  // register bus answer
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // table request
  assign tbl_start = tbl_start_q;
  assign tbl_write = tbl_write_q;
  assign tbl_index = tbl_index_q;
  assign tbl_byte_en = tbl_byte_en_q;

  // packet marks
  assign rx_monitored = rx_mon_q;
  assign tx_monitored = tx_mon_q;

  // priority result
  assign ingress_prio = ingress_prio_q;

endmodule : port_ingress_ctrl_regs

/* File: verification/port_ingress_ctrl_regs_monitor.sv */
module port_ingress_ctrl_regs_monitor
  import port_ingress_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // table request
  input wire logic [7:0] acl_be_msb,
  input wire logic tbl_start,
  input wire logic [15:0] tbl_byte_en,
  // packets
  input wire logic rx_pkt,
  input wire logic tx_pkt,
  input wire logic rx_monitored,
  input wire logic tx_monitored,
  // priority
  input wire logic [2:0] default_prio,
  input wire logic mac_hit,
  input wire logic vlan_hit,
  input wire logic dot1p_hit,
  input wire logic dscp_hit,
  input wire logic acl_hit,
  input wire logic [2:0] ingress_prio
);
  logic any_hit;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // any classifier hit this cycle
  assign any_hit = mac_hit | vlan_hit | dot1p_hit | dscp_hit | acl_hit;

  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("stray read valid");
  a_ctrl_reserved: assert property (reg_rvalid && $past(reg_addr) == ACL_CTRL_OFS[11:0] |-> !reg_rdata[7])
    else $error("acl control bit 7 set");
  a_mirror_reserved: assert property (reg_rvalid && $past(reg_addr) == MIRROR_OFS[11:0]
    |-> (reg_rdata & ~MIRROR_RW_MASK) == 8'h00)
    else $error("mirror reserved bits set");
  a_start_cause: assert property (tbl_start |-> $past(reg_wr) && $past(reg_addr) == ACL_BE_LSB_OFS[11:0])
    else $error("start without enable write");
  a_enable_pair: assert property (tbl_start |-> tbl_byte_en == {$past(acl_be_msb), $past(reg_wdata)})
    else $error("byte enables wrong");
  a_start_pulse: assert property (tbl_start |=> !tbl_start)
    else $error("start longer than a cycle");
  a_rx_cause: assert property (rx_monitored |-> $past(rx_pkt))
    else $error("rx mark without packet");
  a_tx_cause: assert property (tx_monitored |-> $past(tx_pkt))
    else $error("tx mark without packet");
  a_prio_default: assert property ($past(nrst) && !$past(any_hit) |-> ingress_prio == $past(default_prio))
    else $error("default priority not used");
endmodule : port_ingress_ctrl_regs_monitor

bind port_ingress_ctrl_regs port_ingress_ctrl_regs_monitor port_ingress_ctrl_regs_monitor_inst (.core_clk, .nrst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .acl_be_msb, .tbl_start, .tbl_byte_en,
  .rx_pkt, .tx_pkt, .rx_monitored, .tx_monitored, .default_prio, .mac_hit, .vlan_hit, .dot1p_hit, .dscp_hit,
  .acl_hit, .ingress_prio);

/* File: verification/port_ingress_ctrl_regs_tb.sv */
module port_ingress_ctrl_regs_tb
  import port_ingress_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid, tbl_start, tbl_write;
  logic rx_pkt, tx_pkt, rx_monitored, tx_monitored, sniffer_port;
  logic mac_hit, vlan_hit, dot1p_hit, dscp_hit, acl_hit;
  logic [2:0] default_prio, mac_prio, vlan_prio, dot1p_prio, dscp_prio, acl_prio, ingress_prio, e;
  logic [3:0] tbl_index;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, acl_be_msb, rq, c;
  logic [15:0] tbl_byte_en;
  logic [31:0] rnd;
  integer failures, check_count, cycles, seed, i;

  port_ingress_ctrl_regs #(.ACL_LAT(4)) port_ingress_ctrl_regs_inst (.core_clk, .nrst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .acl_be_msb, .tbl_start, .tbl_write, .tbl_index,
    .tbl_byte_en, .rx_pkt, .tx_pkt, .rx_monitored, .tx_monitored, .sniffer_port, .default_prio, .mac_prio,
    .mac_hit, .vlan_prio, .vlan_hit, .dot1p_prio, .dot1p_hit, .dscp_prio, .dscp_hit, .acl_prio, .acl_hit,
    .ingress_prio);

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // tasks, entered and left at a falling edge, except test_done when the hang guard calls it at a rising edge
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1);
    rq = reg_rdata;
  endtask : rd

  // one indirect op, a refused restart, then polling
  task automatic aclop(input logic dir);
    int n;
    rnd = $random(seed);
    acl_be_msb = rnd[23:16];
    wr(ACL_CTRL_OFS[11:0], {3'h0, dir, rnd[3:0]});
    wr(ACL_BE_LSB_OFS[11:0], rnd[15:8]);
    chk({tbl_start, tbl_write, tbl_index}, {1'b1, dir, rnd[3:0]});
    chk(tbl_byte_en, {rnd[23:16], rnd[15:8]});
    wr(ACL_BE_LSB_OFS[11:0], rnd[15:8]);
    chk(tbl_start, 1'b0);
    rd(ACL_CTRL_OFS[11:0]);
    chk(rq[6:5], dir ? 2'h1 : 2'h2);
    n = 0;
    while (rq[6:5] !== 2'h3 && n < 20)
    begin
      rd(ACL_CTRL_OFS[11:0]);
      n = n + 1;
    end
    chk(rq, {3'h3, dir, rnd[3:0]});
  endtask : aclop

  // expected ingress priority
  function automatic logic [2:0] exp_prio(input logic [7:0] ct, input logic [4:0] h, input logic [14:0] p,
    input logic [2:0] d);
    logic [4:0] en;
    logic [2:0] r;
    int ord[5] = '{0, 4, 1, 2, 3};
    en = h & ct[4:0];
    r = 3'h0;
    if (en == 5'h00)
      return d;
    for (int k = 0; k < 5; k++)
      if (en[k])
        r = ct[7] ? ((p[3*k+:3] > r) ? p[3*k+:3] : r) : (r | p[3*k+:3]);
    if (ct[7] || ct[6])
      return r;
    foreach (ord[k])
      if (en[ord[k]])
        return p[3*ord[k]+:3];
    return d;
  endfunction : exp_prio

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 72;
    failures = 0;
    check_count = 0;
    cycles = 0;
    {nrst, reg_wr, reg_rd, rx_pkt, tx_pkt, reg_addr, reg_wdata, acl_be_msb} = '0;
    {default_prio, mac_prio, vlan_prio, dot1p_prio, dscp_prio, acl_prio} = '0;
    {mac_hit, vlan_hit, dot1p_hit, dscp_hit, acl_hit} = '0;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    rd(ACL_CTRL_OFS[11:0]);
    chk(rq[6], 1'b1);
    chk(rq[5], 1'b1);
    chk(rq[4:0], 5'h00);
    rd(MIRROR_OFS[11:0]);
    chk(rq, 8'h00);
    rd(PRIO_CTRL_OFS[11:0]);
    chk(rq, 8'h00);
    rd(12'h123);
    chk(rq, 8'h00);
    wr(ACL_CTRL_OFS[11:0], 8'hFF);
    rd(ACL_CTRL_OFS[11:0]);
    chk(rq, 8'h7F);
    aclop(1'b1);
    aclop(1'b0);
    for (i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      aclop(rnd[0]);
    end
    // mirroring marks and sniffer level, global setup left to software
    for (i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      c = (i == 0) ? 8'h62 : rnd[7:0] & MIRROR_RW_MASK;
      wr(MIRROR_OFS[11:0], c);
      rx_pkt = 1'b1;
      tx_pkt = 1'b1;
      @(negedge core_clk);
      rx_pkt = 1'b0;
      tx_pkt = 1'b0;
      chk(rx_monitored, c[6]);
      chk(tx_monitored, c[5]);
      chk(sniffer_port, c[1]);
      rd(MIRROR_OFS[11:0]);
      chk(rq, c);
    end
    // priority selection with random classifier results
    for (i = 0; i < 60; i++)
    begin
      rnd = $random(seed);
      {mac_prio, vlan_prio, dot1p_prio, dscp_prio, acl_prio} = rnd[14:0];
      {mac_hit, vlan_hit, dot1p_hit, dscp_hit, acl_hit} = (i == 1) ? 5'h00 : rnd[19:15];
      default_prio = rnd[22:20];
      c = (i == 0) ? 8'h00 : rnd[31:24] & PRIO_RW_MASK;
      if (c[7])
        c[6] = 1'b0;
      wr(PRIO_CTRL_OFS[11:0], c);
      @(negedge core_clk);
      e = exp_prio(c, {mac_hit, vlan_hit, dot1p_hit, dscp_hit, acl_hit}, rnd[14:0], default_prio);
      if (c[7])
        chk(ingress_prio, e);
      else if (c[6])
        chk(ingress_prio, e);
      else
        chk(ingress_prio, e);
      rd(PRIO_CTRL_OFS[11:0]);
      chk(rq, c);
    end
    test_done();
  end
endmodule : port_ingress_ctrl_regs_tb
